// *** core/aei_device.sv ***
// Device end: indirect ACL rule table and EEE register bank.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module aei_device #(
  parameter int NPORT = aei_pkg::ACL_PORTS,
  parameter int NEEE = aei_pkg::EEE_PORTS,
  parameter int LPI_TICK_CYC = aei_pkg::LPI_UNIT_CYC
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  aei_link_if.dev LNK,
  input wire logic [NEEE-1:0] TXQ_EMPTY,
  input wire logic [NEEE-1:0] RX_TRAFFIC,
  input wire logic [NEEE-1:0] PHY_WAKING,
  input wire logic [NEEE-1:0] PD_FAULT,
  input wire logic EEE_100BT_EN,
  output logic [NEEE-1:0] LPI_REQ,
  output logic [3:0] NP_ENABLE,
  output logic [NPORT-1:0] RING_SINGLE
);
  localparam int NB = aei_pkg::ACL_ENTRY_BYTES;
  localparam int NE = aei_pkg::ACL_ENTRIES;
  localparam int PW = (NPORT > 1) ? $clog2(NPORT) : 1;
  localparam int EW = (NEEE > 1) ? $clog2(NEEE) : 1;

  logic ack_q;
  logic [7:0] rdata_q;
  logic [7:0] sel_q;
  logic [7:0] off_q;
  logic [7:0] tbl_q [NPORT*NE*NB];
  logic [7:0] hold_q [NPORT*NB];
  logic [13:0] be_q [NPORT];
  logic [4:0] ctl_q [NPORT];
  logic [NPORT-1:0] rd_done_q;
  logic [NPORT-1:0] wr_done_q;
  logic [NPORT-1:0] ring_q;
  logic busy_q;
  logic eng_wr_q;
  logic [PW-1:0] eng_port_q;
  logic [3:0] eng_idx_q;
  logic [3:0] eng_cnt_q;
  logic lpi_stop_q;
  logic [15:0] wait_q;
  logic [3:0] np_q;
  logic [31:0] tick_cnt_q;
  logic [15:0] werr_q [NEEE];
  logic [NEEE-1:0] pd_q;
  logic [NEEE-1:0] lpi_q;

  // Link strobes; one request is taken per ack so none is seen twice.
  wire take = LNK.req & ~ack_q;
  wire lwr = take & LNK.we;
  wire lrd = take & ~LNK.we;
  wire sel_wr = lwr & (LNK.addr == aei_pkg::LNK_SELECT);
  wire off_wr = lwr & (LNK.addr == aei_pkg::LNK_OFFSET);
  wire rd_mode = sel_q[aei_pkg::SEL_DIR_BIT];
  wire dat_wr = lwr & (LNK.addr == aei_pkg::LNK_DATA) & ~rd_mode;
  wire dat_rd = lrd & (LNK.addr == aei_pkg::LNK_DATA) & rd_mode;

  // Table and port decode of the select register.
  wire [2:0] tbl = sel_q[7:aei_pkg::SEL_TBL_LSB];
  wire [3:0] pnum = sel_q[3:0];
  wire acl_hit = (tbl == aei_pkg::TBL_ACL) && (pnum != 4'h0)
    && (int'(pnum) <= NPORT);
  wire [PW-1:0] ap = PW'(pnum - 4'h1);
  wire eg_hit = (tbl == aei_pkg::TBL_EEE)
    && (pnum == aei_pkg::EEE_GLOBAL_PORT);
  wire ep_hit = (tbl == aei_pkg::TBL_EEE)
    && (pnum >= aei_pkg::EEE_FIRST_PORT)
    && (int'(pnum) < int'(aei_pkg::EEE_FIRST_PORT) + NEEE);
  wire [EW-1:0] ep = EW'(pnum - aei_pkg::EEE_FIRST_PORT);
  wire [7:0] off_even = {off_q[7:1], 1'b0};
  wire lo = off_q[0];
  wire in_hold = off_q <= aei_pkg::ACL_HOLD_LAST;
  wire [3:0] hb = off_q[3:0];

  // ACL byte as seen through the data register.
  wire [7:0] acl_byte =
    in_hold ? hold_q[int'(ap) * NB + int'(hb)] :
    (off_q == aei_pkg::ACL_BE_HI) ? {2'h0, be_q[ap][13:8]} :
    (off_q == aei_pkg::ACL_BE_LO) ? be_q[ap][7:0] :
    (off_q == aei_pkg::ACL_CTRL) ? {1'b0, wr_done_q[ap], rd_done_q[ap],
      ctl_q[ap]} :
    (off_q == aei_pkg::ACL_CTRL2) ? {7'h00, ring_q[ap]} : 8'h00;

  // Sixteen bit EEE word for the offset pair, split by the low bit.
  wire [15:0] eg_word =
    (off_even == aei_pkg::EEE_QBUF) ? (aei_pkg::QBUF_FIXED |
      (16'(lpi_stop_q) << aei_pkg::LPI_STOP_BIT)) :
    (off_even == aei_pkg::EEE_WAIT) ? wait_q :
    (off_even == aei_pkg::EEE_NPEN) ? (aei_pkg::NPEN_FIXED | {12'h000, np_q}) :
    (off_even == aei_pkg::EEE_MINLPI) ? aei_pkg::MINLPI_RST :
    (off_even == aei_pkg::EEE_WAKETH) ? aei_pkg::WAKE_TH :
    (off_even == aei_pkg::EEE_PCS) ? aei_pkg::PCS_RST : 16'h0000;
  wire [15:0] ep_word =
    (off_even == aei_pkg::EEE_ANX) ? (aei_pkg::ANX_FIXED |
      (16'(pd_q[ep]) << aei_pkg::PD_FAULT_BIT)) :
    (off_even == aei_pkg::EEE_WERR) ? werr_q[ep] : 16'h0000;
  wire [15:0] ee_word = eg_hit ? eg_word : ep_hit ? ep_word : 16'h0000;
  wire [7:0] eee_byte = lo ? ee_word[7:0] : ee_word[15:8];
  wire [7:0] fetch = acl_hit ? acl_byte : eee_byte;
  wire [7:0] rd_mux = (LNK.addr == aei_pkg::LNK_SELECT) ? sel_q :
    (LNK.addr == aei_pkg::LNK_OFFSET) ? off_q :
    (LNK.addr == aei_pkg::LNK_DATA) ? fetch : 8'h00;

  // Host side ACL writes and entry command start.
  wire acl_wr = dat_wr & acl_hit;
  wire start = acl_wr & (off_q == aei_pkg::ACL_CTRL) & ~busy_q;
  wire eg_wr = dat_wr & eg_hit;
  wire [3:0] eb = 4'(NB - 1) - eng_cnt_q;
  wire eng_en = be_q[eng_port_q][eb];
  wire [31:0] h_i = int'(eng_port_q) * NB + int'(eng_cnt_q);
  wire [31:0] t_i = (int'(eng_port_q) * NE + int'(eng_idx_q)) * NB
    + int'(eng_cnt_q);
  wire tick = tick_cnt_q == 32'(LPI_TICK_CYC - 1);

  assign LNK.ack = ack_q;
  assign LNK.rdata = rdata_q;
  assign LPI_REQ = lpi_q;
  assign NP_ENABLE = np_q;
  assign RING_SINGLE = ring_q;

  // Link answer and the select and offset registers.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
      sel_q <= 8'h00;
      off_q <= 8'h00;
    end else if (CE) begin
      ack_q <= take;
      if (lrd) rdata_q <= rd_mux;
      if (sel_wr) sel_q <= LNK.wdata;
      if (off_wr) off_q <= LNK.wdata;
    end
  end

  // ACL registers, holding buffer, table and the byte copy engine.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < NPORT*NE*NB; i++) tbl_q[i] <= 8'h00;
      for (int i = 0; i < NPORT*NB; i++) hold_q[i] <= 8'h00;
      for (int p = 0; p < NPORT; p++) begin
        be_q[p] <= 14'h0000;
        ctl_q[p] <= 5'h00;
      end
      rd_done_q <= '1;
      wr_done_q <= '1;
      ring_q <= '0;
      busy_q <= 1'b0;
      eng_wr_q <= 1'b0;
      eng_port_q <= '0;
      eng_idx_q <= 4'h0;
      eng_cnt_q <= 4'h0;
    end else if (CE) begin
      if (acl_wr && in_hold) hold_q[int'(ap) * NB + int'(hb)] <= LNK.wdata;
      if (acl_wr && off_q == aei_pkg::ACL_BE_HI)
        be_q[ap][13:8] <= LNK.wdata[5:0];
      if (acl_wr && off_q == aei_pkg::ACL_BE_LO) be_q[ap][7:0] <= LNK.wdata;
      if (acl_wr && off_q == aei_pkg::ACL_CTRL2)
        ring_q[ap] <= LNK.wdata[0];
      if (start) begin
        ctl_q[ap] <= LNK.wdata[4:0];
        eng_wr_q <= LNK.wdata[aei_pkg::CTRL_WRITE_BIT];
        eng_idx_q <= LNK.wdata[3:0];
        eng_port_q <= ap;
        eng_cnt_q <= 4'h0;
        busy_q <= 1'b1;
        if (LNK.wdata[aei_pkg::CTRL_WRITE_BIT]) wr_done_q[ap] <= 1'b0;
        else rd_done_q[ap] <= 1'b0;
      end
      if (busy_q) begin
        if (eng_en && eng_wr_q) tbl_q[t_i] <= hold_q[h_i];
        if (eng_en && !eng_wr_q) hold_q[h_i] <= tbl_q[t_i];
        eng_cnt_q <= eng_cnt_q + 4'h1;
        if (eng_cnt_q == 4'(NB - 1)) begin
          busy_q <= 1'b0;
          if (eng_wr_q) wr_done_q[eng_port_q] <= 1'b1;
          else rd_done_q[eng_port_q] <= 1'b1;
        end
      end
    end
  end

  // EEE global registers and the shared empty queue tick.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      lpi_stop_q <= 1'b0;
      wait_q <= aei_pkg::WAIT_RST;
      np_q <= aei_pkg::NPEN_RST;
      tick_cnt_q <= 32'h0000_0000;
    end else if (CE) begin
      tick_cnt_q <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
      if (eg_wr && off_q == (aei_pkg::EEE_QBUF | 8'h01))
        lpi_stop_q <= LNK.wdata[aei_pkg::LPI_STOP_BIT];
      if (eg_wr && off_q == aei_pkg::EEE_WAIT) wait_q[15:8] <= LNK.wdata;
      if (eg_wr && off_q == (aei_pkg::EEE_WAIT | 8'h01))
        wait_q[7:0] <= LNK.wdata;
      if (eg_wr && off_q == (aei_pkg::EEE_NPEN | 8'h01))
        np_q <= LNK.wdata[3:0];
    end
  end

  // Per copper port wakeup check, fault latch and LPI request.
  for (genvar g = 0; g < NEEE; g++) begin : g_eee
    logic [15:0] wake_cnt_q;
    logic [15:0] empty_q;
    wire here = dat_rd & ep_hit & (ep == EW'(g)) & lo;
    wire werr_clr = here & (off_even == aei_pkg::EEE_WERR);
    wire pd_clr = here & (off_even == aei_pkg::EEE_ANX);
    wire over = PHY_WAKING[g] & (wake_cnt_q == aei_pkg::WAKE_TH);
    wire stop = ~TXQ_EMPTY[g] | ~EEE_100BT_EN
      | (RX_TRAFFIC[g] & lpi_stop_q);
    always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
        wake_cnt_q <= 16'h0000;
        empty_q <= 16'h0000;
        werr_q[g] <= 16'h0000;
        pd_q[g] <= 1'b0;
        lpi_q[g] <= 1'b0;
      end else if (CE) begin
        if (!PHY_WAKING[g]) wake_cnt_q <= 16'h0000;
        else if (wake_cnt_q != 16'hFFFF) wake_cnt_q <= wake_cnt_q + 16'h0001;
        if (over) werr_q[g] <= werr_clr ? 16'h0001 :
          (werr_q[g] == 16'hFFFF) ? werr_q[g] : werr_q[g] + 16'h0001;
        else if (werr_clr) werr_q[g] <= 16'h0000;
        if (PD_FAULT[g]) pd_q[g] <= 1'b1;
        else if (pd_clr) pd_q[g] <= 1'b0;
        if (stop) begin
          empty_q <= 16'h0000;
          lpi_q[g] <= 1'b0;
        end else begin
          if (tick && empty_q != 16'hFFFF) empty_q <= empty_q + 16'h0001;
          lpi_q[g] <= empty_q > wait_q;
        end
      end
    end
  end
endmodule // aei_device
`default_nettype wire

// *** core/aei_host.sv ***
// Host end: APB controller that issues single byte link accesses.
`timescale 1ns/1ps
`default_nettype none
module aei_host (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  aei_link_if.host LNK
);
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic req_q;
  logic we_q;
  logic [7:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] last_q;

  // APB decode; the access phase always waits one cycle.
  wire acc = PSEL & PENABLE & ~pready_q;
  wire is_cmd = PADDR == aei_pkg::HOST_CMD;
  wire is_st = PADDR == aei_pkg::HOST_STATUS;
  wire cmd_go = acc & PWRITE & is_cmd & ~req_q;
  wire bad = ~(is_cmd | is_st) | (PWRITE & is_cmd & req_q)
    | (PWRITE & is_st);
  wire [31:0] status = {16'h0000, last_q, 5'h00,
    last_q[aei_pkg::CTRL_WR_DONE_BIT],
    last_q[aei_pkg::CTRL_RD_DONE_BIT],
    req_q};
  wire [31:0] cmd_rb = {15'h0000, we_q, addr_q, wdata_q};

  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign PRDATA = prdata_q;
  assign LNK.req = req_q;
  assign LNK.we = we_q;
  assign LNK.addr = addr_q;
  assign LNK.wdata = wdata_q;

  // APB answer registers.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (CE) begin
      pready_q <= acc;
      pslverr_q <= acc & bad;
      if (acc) prdata_q <= PWRITE ? 32'h0000_0000 : is_st ? status :
        is_cmd ? cmd_rb : 32'h0000_0000;
    end
  end

  // One link request held until the device acknowledges it.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      req_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      last_q <= 8'h00;
    end else if (CE) begin
      if (cmd_go) begin
        req_q <= 1'b1;
        we_q <= PWDATA[aei_pkg::CMD_WE_BIT];
        addr_q <= PWDATA[15:8];
        wdata_q <= PWDATA[7:0];
      end else if (req_q && LNK.ack) begin
        req_q <= 1'b0;
        if (!we_q) last_q <= LNK.rdata;
      end
    end
  end
endmodule // aei_host
`default_nettype wire

// *** core/aei_link_if.sv ***
// Byte wide register link between the host controller and the device.
`timescale 1ns/1ps
`default_nettype none
interface aei_link_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  modport dev (input req, input we, input addr, input wdata,
    output ack, output rdata);
  modport host (output req, output we, output addr, output wdata,
    input ack, input rdata);
endinterface
`default_nettype wire

// *** core/aei_pkg.sv ***
// Shared constants for the indirect ACL and EEE register access block.
package aei_pkg;
  // Byte addresses of the three indirect access registers on the link.
  localparam logic [7:0] LNK_SELECT = 8'h6E;
  localparam logic [7:0] LNK_OFFSET = 8'h6F;
  localparam logic [7:0] LNK_DATA = 8'hA0;
  // Fields of the select register.
  localparam int SEL_TBL_LSB = 5;
  localparam int SEL_DIR_BIT = 4;
  localparam logic [2:0] TBL_ACL = 3'h2;
  localparam logic [2:0] TBL_EEE = 3'h1;
  // Rule table geometry.
  localparam int ACL_PORTS = 5;
  localparam int ACL_ENTRIES = 16;
  localparam int ACL_ENTRY_BYTES = 14;
  // Offsets inside the ACL table of one port.
  localparam logic [7:0] ACL_HOLD_LAST = 8'h0D;
  localparam logic [7:0] ACL_BE_HI = 8'h10;
  localparam logic [7:0] ACL_BE_LO = 8'h11;
  localparam logic [7:0] ACL_CTRL = 8'h12;
  localparam logic [7:0] ACL_CTRL2 = 8'h13;
  // Fields of the access control register.
  localparam int CTRL_WR_DONE_BIT = 6;
  localparam int CTRL_RD_DONE_BIT = 5;
  localparam int CTRL_WRITE_BIT = 4;
  // EEE port numbers in the select nibble.
  localparam logic [3:0] EEE_GLOBAL_PORT = 4'h0;
  localparam logic [3:0] EEE_FIRST_PORT = 4'h3;
  localparam int EEE_PORTS = 2;
  // EEE global register offsets, high byte at the even offset.
  localparam logic [7:0] EEE_QBUF = 8'h30;
  localparam logic [7:0] EEE_WAIT = 8'h32;
  localparam logic [7:0] EEE_NPEN = 8'h34;
  localparam logic [7:0] EEE_MINLPI = 8'h36;
  localparam logic [7:0] EEE_WAKETH = 8'h38;
  localparam logic [7:0] EEE_PCS = 8'h3A;
  // EEE per port register offsets.
  localparam logic [7:0] EEE_ANX = 8'h0C;
  localparam logic [7:0] EEE_WERR = 8'h2A;
  // Reset and fixed values of the EEE registers.
  localparam logic [15:0] QBUF_FIXED = 16'h4010;
  localparam int LPI_STOP_BIT = 7;
  localparam logic [15:0] WAIT_RST = 16'h0010;
  localparam logic [15:0] NPEN_FIXED = 16'h6800;
  localparam logic [3:0] NPEN_RST = 4'hF;
  localparam logic [15:0] MINLPI_RST = 16'h0000;
  localparam logic [15:0] WAKE_TH = 16'h0201;
  localparam logic [15:0] PCS_RST = 16'h0001;
  localparam logic [15:0] ANX_FIXED = 16'h0060;
  localparam int PD_FAULT_BIT = 4;
  // Wait count unit of the empty queue timer.
  localparam int CLK_FREQ_HZ = 25000000;
  localparam int LPI_UNIT_US = 1300;
  localparam int LPI_UNIT_CYC = LPI_UNIT_US * (CLK_FREQ_HZ / 1000000);
  // Registers of the host controller on APB.
  localparam logic [11:0] HOST_CMD = 12'h000;
  localparam logic [11:0] HOST_STATUS = 12'h004;
  localparam int CMD_WE_BIT = 16;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_RD_DONE_BIT = 1;
  localparam int ST_WR_DONE_BIT = 2;
endpackage

// *** verification/aei_checker_asserts.sv ***
// Link handshake and fixed read value checks for the indirect access link.
`timescale 1ns/1ps
`default_nettype none
module aei_checker (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata
);
  logic [7:0] sel_q;
  logic [7:0] off_q;
  // A write completes at its ack; a data read is taken on its first cycle.
  wire logic wr_done = req && ack && we;
  wire logic rd_take = req && !ack && !we && addr == aei_pkg::LNK_DATA;
  // Track the select and offset bytes that the host last completed.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sel_q <= 8'h00;
      off_q <= 8'h00;
    end else begin
      if (wr_done && addr == aei_pkg::LNK_SELECT) sel_q <= wdata;
      if (wr_done && addr == aei_pkg::LNK_OFFSET) off_q <= wdata;
    end
  end
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence s_take; req && !ack; endsequence
  sequence s_answer; ack ##1 (!ack && !req); endsequence
  property p_answer; s_take |=> s_answer; endproperty
  property p_idle; !req |=> !ack; endproperty
  property p_hold;
    s_take |=> req && $stable(addr) && $stable(we) && $stable(wdata);
  endproperty
  property p_rdata; !(req && !ack && !we) |=> $stable(rdata); endproperty
  property p_wake_th;
    rd_take && sel_q == 8'h30 && off_q[7:1] == 7'h1C
      |=> rdata == (off_q[0] ? 8'h01 : 8'h02);
  endproperty
  property p_qbuf;
    rd_take && sel_q == 8'h30 && off_q == 8'h30 |=> rdata == 8'h40;
  endproperty
  property p_anx;
    rd_take && sel_q inside {8'h33, 8'h34} && off_q == 8'h0D
      |=> rdata[6:5] == 2'h3 && !rdata[7];
  endproperty
  property p_ctrl;
    rd_take && sel_q[7:4] == 4'h5 && off_q == 8'h12 |=> !rdata[7];
  endproperty
  a_answer: assert property (p_answer) else $error("link answer late");
  a_idle: assert property (p_idle) else $error("ack without request");
  a_hold: assert property (p_hold) else $error("request not held");
  a_rdata: assert property (p_rdata) else $error("read byte moved");
  a_wake_th: assert property (p_wake_th) else $error("threshold");
  a_qbuf: assert property (p_qbuf) else $error("reserved byte");
  a_anx: assert property (p_anx) else $error("expansion bits");
  a_ctrl: assert property (p_ctrl) else $error("control bit 7");
endmodule // aei_checker
`default_nettype wire

// *** verification/test_acl_eee_indirect_access.sv ***
// Self-checking bench joining the host controller and the device end.
`timescale 1ns/1ps
`default_nettype none
module test_acl_eee_indirect_access;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, een = 1'h0, ce = 1'h1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e;
  logic [1:0] txq = 2'h0, rx = 2'h0, wake = 2'h0, pd = 2'h0, lpi;
  logic [3:0] npen;
  logic [4:0] ring;
  logic [7:0] v, dat [14];
  logic [13:0] be;
  logic [3:0] port, ent;
  int err_total = 0;
  int total_checks = 0;
  // Select, offset and expected byte, with a flag for read-only places.
  logic [24:0] tbl [15] = '{25'h1303040, 25'h0303110, 25'h0303200,
    25'h0303310, 25'h1303468, 25'h030350F, 25'h1303600, 25'h1303700,
    25'h1303802, 25'h1303901, 25'h1303A00, 25'h1303B01, 25'h1330C00,
    25'h1340D60, 25'h0511260};
  aei_link_if i_aei_link_if ();
  aei_device #(.LPI_TICK_CYC(4)) i_aei_device (.CLK(clk), .NRST(nrst),
    .CE(ce), .LNK(i_aei_link_if.dev), .TXQ_EMPTY(txq), .RX_TRAFFIC(rx),
    .PHY_WAKING(wake), .PD_FAULT(pd), .EEE_100BT_EN(een), .LPI_REQ(lpi),
    .NP_ENABLE(npen), .RING_SINGLE(ring));
  aei_host i_aei_host (.CLK(clk), .NRST(nrst), .CE(ce), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .LNK(i_aei_link_if.host));
  aei_checker i_aei_checker (.CLK(clk), .NRST(nrst),
    .req(i_aei_link_if.req), .we(i_aei_link_if.we),
    .addr(i_aei_link_if.addr), .wdata(i_aei_link_if.wdata),
    .ack(i_aei_link_if.ack), .rdata(i_aei_link_if.rdata));
  // The clock toggles every 20 ns, a period of 40 ns.
  always #20 clk = ~clk;
  // Expected entry byte after a commit through the given enables.
  function automatic logic [7:0] exp_byte(logic [13:0] m, int b,
    logic [7:0] d);
    return m[13 - b] ? d : 8'h00;
  endfunction
  task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    chk("pready", 32'h1, 32'(pready));
  endtask
  // One link byte access through the host command and status words.
  task automatic lnk(logic w, logic [7:0] a, logic [7:0] d);
    int n;
    apb(1'h1, aei_pkg::HOST_CMD, {15'h0, w, a, d});
    n = 0;
    do begin
      apb(1'h0, aei_pkg::HOST_STATUS, 32'h0);
      n++;
    end while (r[0] !== 1'h0 && n < 30);
    chk("link busy", 32'h0, 32'(r[0]));
    v = r[15:8];
  endtask
  task automatic wr(logic [7:0] s, logic [7:0] o, logic [7:0] d);
    lnk(1'h1, aei_pkg::LNK_SELECT, s);
    lnk(1'h1, aei_pkg::LNK_OFFSET, o);
    lnk(1'h1, aei_pkg::LNK_DATA, d);
  endtask
  task automatic rd(logic [7:0] s, logic [7:0] o);
    lnk(1'h1, aei_pkg::LNK_SELECT, s);
    lnk(1'h1, aei_pkg::LNK_OFFSET, o);
    lnk(1'h0, aei_pkg::LNK_DATA, 8'h00);
  endtask
  // Poll one status bit of the access control byte until it reads one.
  task automatic poll(logic [7:0] s, int k);
    int n;
    n = 0;
    do begin
      rd(s, aei_pkg::ACL_CTRL);
      n++;
    end while (v[k] !== 1'h1 && n < 30);
    chk("status", 32'h1, 32'(v[k]));
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog that cuts a hung run short.
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    $display("[ERR] watchdog expected done seen hang");
    end_sim;
  end
  // Main sequence: reset values, refusals, rule entries, then EEE state.
  initial begin
    void'($urandom(96));
    repeat (6) @(posedge clk);
    nrst <= 1'h1;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 15; i++) begin
        if (p == 1 && tbl[i][24])
          wr(tbl[i][23:16] & 8'hEF, tbl[i][15:8], 8'hA5);
        rd(tbl[i][23:16], tbl[i][15:8]);
        chk("regs", 32'(tbl[i][7:0]), 32'(v));
      end
    end
    apb(1'h0, 12'h008, 32'h0);
    chk("unmapped", 32'h1, 32'(e));
    apb(1'h1, aei_pkg::HOST_STATUS, 32'h0);
    chk("status write", 32'h1, 32'(e));
    for (int it = 0; it < 2; it++) begin
      port = (it == 0) ? 4'h5 : 4'(1 + $urandom % 4);
      ent = (it == 0) ? 4'hF : 4'($urandom % 15);
      be = (it == 0) ? 14'h1555 : 14'h3FFF;
      poll(8'h50 | port, aei_pkg::CTRL_WR_DONE_BIT);
      for (int b = 0; b < 14; b++) begin
        dat[b] = 8'($urandom);
        wr(8'h40 | port, 8'(b), dat[b]);
      end
      wr(8'h40 | port, aei_pkg::ACL_BE_HI, {2'h0, be[13:8]});
      wr(8'h40 | port, aei_pkg::ACL_BE_LO, be[7:0]);
      wr(8'h40 | port, aei_pkg::ACL_CTRL, {4'h1, ent});
      // Read the control byte at once; the copy engine is still running.
      lnk(1'h0, aei_pkg::LNK_DATA, 8'h00);
      chk("write busy", 32'h0, 32'(v[6]));
      poll(8'h50 | port, aei_pkg::CTRL_WR_DONE_BIT);
      chk("control", 32'({1'h1, ent}), 32'(v[4:0]));
      for (int b = 0; b < 14; b++) wr(8'h40 | port, 8'(b), ~dat[b]);
      wr(8'h40 | port, aei_pkg::ACL_BE_HI, 8'h3F);
      wr(8'h40 | port, aei_pkg::ACL_BE_LO, 8'hFF);
      wr(8'h40 | port, aei_pkg::ACL_CTRL, {4'h0, ent});
      lnk(1'h0, aei_pkg::LNK_DATA, 8'h00);
      chk("read busy", 32'h0, 32'(v[5]));
      poll(8'h50 | port, aei_pkg::CTRL_RD_DONE_BIT);
      chk("control", 32'({1'h0, ent}), 32'(v[4:0]));
      for (int b = 0; b < 14; b++) begin
        rd(8'h50 | port, 8'(b));
        chk("entry", 32'(exp_byte(be, b, dat[b])), 32'(v));
      end
    end
    wr(8'h20, aei_pkg::EEE_WAIT, 8'h00);
    wr(8'h20, 8'h33, 8'h02);
    txq <= 2'h3;
    een <= 1'h1;
    repeat (6) @(posedge clk);
    chk("lpi early", 32'h0, 32'(lpi));
    repeat (20) @(posedge clk);
    chk("lpi", 32'h3, 32'(lpi));
    rx <= 2'h3;
    repeat (3) @(posedge clk);
    chk("lpi kept", 32'h3, 32'(lpi));
    wr(8'h20, 8'h31, 8'h80);
    repeat (2) @(posedge clk);
    chk("lpi stop", 32'h0, 32'(lpi));
    rx <= 2'h0;
    txq <= 2'h0;
    wake <= 2'h3;
    repeat (100) @(posedge clk);
    wake <= 2'h1;
    repeat (440) @(posedge clk);
    wake <= 2'h0;
    rd(8'h33, 8'h2B);
    chk("wake err", 32'h1, 32'(v));
    rd(8'h33, 8'h2B);
    chk("wake clr", 32'h0, 32'(v));
    rd(8'h34, 8'h2B);
    chk("short wake", 32'h0, 32'(v));
    pd <= 2'h2;
    @(posedge clk);
    pd <= 2'h0;
    rd(8'h34, aei_pkg::ACL_HOLD_LAST);
    chk("fault", 32'h70, 32'(v));
    rd(8'h34, aei_pkg::ACL_HOLD_LAST);
    chk("fault clr", 32'h60, 32'(v));
    // A fault pulse while the clock enable is low must leave no trace.
    ce <= 1'h0;
    pd <= 2'h1;
    @(posedge clk);
    ce <= 1'h1;
    pd <= 2'h0;
    rd(8'h33, aei_pkg::ACL_HOLD_LAST);
    chk("frozen", 32'h60, 32'(v));
    wr(8'h20, 8'h35, 8'h05);
    chk("np enable", 32'h5, 32'(npen));
    wr(8'h43, aei_pkg::ACL_CTRL2, 8'h01);
    chk("ring", 32'h04, 32'(ring));
    rd(8'h53, aei_pkg::ACL_CTRL2);
    chk("ring read", 32'h01, 32'(v));
    end_sim;
  end
endmodule // test_acl_eee_indirect_access
`default_nettype wire
